// [hw/ssr_status.sv]
// Status byte, event flags, masks and service-request generation
`timescale 1ns/1ps
`include "ssr_map.svh"
module ssr_status
  import ssr_pkg::*;
#(
  parameter int QUEUE_DEPTH = `SSR_QUEUE_DEPTH
) (
  // Clock and reset
  input  wire logic       ref_clk_i,
  input  wire logic       resetn_i,
  // Power supply indication from the supervisor (asynchronous)
  input  wire logic       power_good_i,
  // Parser and executor events, one-cycle pulses, plus the ops_pending_i level
  input  wire logic       command_error_i,
  input  wire logic       execution_error_i,
  input  wire logic       device_error_i,
  input  wire logic       opc_monitor_i,
  input  wire logic       ops_pending_i,
  // Response formatter
  input  wire logic       resp_push_i,
  input  wire logic [7:0] resp_data_i,
  input  wire logic       resp_end_i,
  output logic            resp_ready_o,
  // Controller reads of the response queue
  input  wire logic       resp_read_i,
  output logic [7:0]      resp_data_o,
  output logic            resp_end_o,
  output logic            resp_valid_o,
  // Status access by the controller
  input  wire logic       serial_poll_i,
  input  wire logic       stb_query_i,
  output logic [7:0]      stb_data_o,
  output logic            stb_valid_o,
  // Mask writes and reads
  input  wire logic       srq_mask_wr_i,
  input  wire logic       evt_mask_wr_i,
  input  wire logic [7:0] mask_wdata_i,
  output logic [7:0]      srq_mask_o,
  output logic [7:0]      evt_mask_o,
  // Event flag register read, clears on read
  input  wire logic       evt_read_i,
  output logic [15:0]     evt_data_o,
  output logic            evt_valid_o,
  // Bus service-request line
  output logic            srq_o
);

  // ************************************************************
  // Synchronisers
  // ************************************************************
  logic pwr_meta_reg;
  logic pwr_sync_reg;
  logic pwr_prev_reg;

  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      pwr_meta_reg <= 1'b0;
      pwr_sync_reg <= 1'b0;
      pwr_prev_reg <= 1'b0;
    end else begin
      pwr_meta_reg <= power_good_i;
      pwr_sync_reg <= pwr_meta_reg;
      pwr_prev_reg <= pwr_sync_reg;
    end
  end

  wire power_on_event = pwr_sync_reg && !pwr_prev_reg;

  // ************************************************************
  // Response queue
  // ************************************************************
  ssr_queue_if qif ();

  ssr_resp_queue #(
    .DEPTH (QUEUE_DEPTH)
  ) u_queue (
    .ref_clk_i (ref_clk_i),
    .resetn_i  (resetn_i),
    .q         (qif.queue)
  );

  // answer bytes and end markers enter, reads remove them
  assign qif.push      = resp_push_i;
  assign qif.push_data = {resp_end_i, resp_data_i};
  assign qif.pop       = resp_read_i;
  assign resp_ready_o  = !qif.full;

  logic rd_valid_reg;

  wire rd_accept = resp_read_i && qif.nonempty;

  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rd_valid_reg <= 1'b0;
    end else begin
      rd_valid_reg <= rd_accept;
    end
  end

  // Pop data lands one cycle after the read; align valid with it
  assign resp_valid_o = rd_valid_reg;
  assign resp_data_o  = qif.pop_data[7:0];
  assign resp_end_o   = qif.pop_data[8];

  // ************************************************************
  // Operation-complete monitor
  // ************************************************************
  ssr_opc_state_t opc_reg;
  ssr_opc_state_t opc_next;
  logic           opc_event;

  // armed by the monitor command, fires when nothing is pending
  always_comb begin
    opc_next  = opc_reg;
    opc_event = 1'b0;
    unique case (opc_reg)
      SSR_OPC_IDLE: begin
        if (opc_monitor_i) begin
          opc_next = SSR_OPC_ARMED;
        end
      end
      SSR_OPC_ARMED: begin
        if (!ops_pending_i) begin
          opc_event = 1'b1;
          opc_next  = SSR_OPC_IDLE;
        end
      end
      default: begin
        opc_next = SSR_OPC_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      opc_reg <= SSR_OPC_IDLE;
    end else begin
      opc_reg <= opc_next;
    end
  end

  // ************************************************************
  // Event flags
  // ************************************************************
  logic [15:0] evt_flags_reg;
  logic [15:0] evt_set;
  logic [15:0] evt_flags_next;

  always_comb begin
    evt_set = 16'h0000;
    evt_set[`SSR_EVT_OPC_BIT] = opc_event;
    evt_set[`SSR_EVT_QYE_BIT] = qif.underflow || qif.overflow;
    evt_set[`SSR_EVT_DDE_BIT] = device_error_i;
    evt_set[`SSR_EVT_EXE_BIT] = execution_error_i;
    evt_set[`SSR_EVT_CME_BIT] = command_error_i;
    evt_set[`SSR_EVT_PON_BIT] = power_on_event;
  end

  // read clears, but a new event in that cycle survives
  assign evt_flags_next = ((evt_read_i ? 16'h0000 : evt_flags_reg)
                           | evt_set) & `SSR_EVT_USED;

  logic [15:0] evt_rd_reg;
  logic [15:0] evt_rd_next;
  logic        evt_valid_reg;

  // Read data holds its last value until the next read
  assign evt_rd_next = evt_read_i ? evt_flags_reg : evt_rd_reg;

  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      evt_flags_reg <= `SSR_EVT_FLAGS_RST;
    end else begin
      evt_flags_reg <= evt_flags_next;
    end
  end

  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      evt_rd_reg    <= 16'h0000;
      evt_valid_reg <= 1'b0;
    end else begin
      evt_rd_reg    <= evt_rd_next;
      evt_valid_reg <= evt_read_i;
    end
  end

  assign evt_data_o  = evt_rd_reg;
  assign evt_valid_o = evt_valid_reg;

  // ************************************************************
  // Mask registers
  // ************************************************************
  logic [7:0] srq_mask_reg;
  logic [7:0] evt_mask_reg;

  wire [7:0] srq_mask_next = srq_mask_wr_i ? mask_wdata_i : srq_mask_reg;
  wire [7:0] evt_mask_next = evt_mask_wr_i ? mask_wdata_i : evt_mask_reg;

  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      srq_mask_reg <= `SSR_SRQ_MASK_RST;
    end else begin
      srq_mask_reg <= srq_mask_next;
    end
  end

  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      evt_mask_reg <= `SSR_EVT_MASK_RST;
    end else begin
      evt_mask_reg <= evt_mask_next;
    end
  end

  assign srq_mask_o = srq_mask_reg;
  assign evt_mask_o = evt_mask_reg;

  // ************************************************************
  // Status summary and service request
  // ************************************************************
  // Any bit that is both set and enabled
  function automatic logic ssr_any_masked(input logic [7:0] v,
                                          input logic [7:0] m);
    ssr_any_masked = |(v & m);
  endfunction : ssr_any_masked

  wire queue_nonempty_flag = qif.nonempty;
  wire event_summary_flag  =
    ssr_any_masked(evt_flags_reg[7:0], evt_mask_reg);

  // Summary bits only, before the request bit is added
  logic [7:0] stb_base;

  always_comb begin
    stb_base = 8'h00;
    stb_base[`SSR_STB_MAV_BIT] = queue_nonempty_flag;
    stb_base[`SSR_STB_ESB_BIT] = event_summary_flag;
  end

  // summary of enabled bits 4 and 5
  wire master_summary_flag = ssr_any_masked(stb_base, srq_mask_reg);

  logic mss_prev_reg;
  logic request_service_flag;
  logic rqs_reg;

  // request raised on a rising summary edge
  wire rqs_rise = master_summary_flag && !mss_prev_reg;

  // request-service bit held while summary persists
  wire rqs_next = rqs_rise || (rqs_reg && master_summary_flag);

  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      mss_prev_reg <= 1'b0;
    end else begin
      mss_prev_reg <= master_summary_flag;
    end
  end

  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rqs_reg <= 1'b0;
    end else begin
      rqs_reg <= rqs_next;
    end
  end

  // Gated by the summary so a poll and a query always agree
  assign request_service_flag = master_summary_flag && (rqs_reg || rqs_rise);

  // bus request line follows the request-service bit
  assign srq_o = rqs_reg;

  // Summary bits come in as an argument so callers re-evaluate on change
  function automatic ssr_byte_t ssr_stb(input ssr_byte_t base,
                                        input logic      b6);
    ssr_stb = base;
    ssr_stb[`SSR_STB_RQS_BIT] = b6;
    ssr_stb = ssr_stb & `SSR_STB_USED;
  endfunction : ssr_stb

  logic [7:0] stb_reg;
  logic       stb_valid_reg;

  // poll returns request flag, query returns summary
  wire [7:0] stb_poll  = ssr_stb(stb_base, request_service_flag);
  wire [7:0] stb_query = ssr_stb(stb_base, master_summary_flag);

  // Poll wins over a query in the same cycle
  wire [7:0] stb_next = serial_poll_i ? stb_poll :
                        stb_query_i   ? stb_query : stb_reg;

  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      stb_reg <= 8'h00;
    end else begin
      stb_reg <= stb_next;
    end
  end

  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      stb_valid_reg <= 1'b0;
    end else begin
      stb_valid_reg <= serial_poll_i || stb_query_i;
    end
  end

  assign stb_data_o  = stb_reg;
  assign stb_valid_o = stb_valid_reg;

endmodule : ssr_status

// [pkg/ssr_map.svh]
// Constants for the status and service-request block
`ifndef SSR_MAP_SVH
`define SSR_MAP_SVH

// Status summary byte bit positions
`define SSR_STB_MAV_BIT   4
`define SSR_STB_ESB_BIT   5
`define SSR_STB_RQS_BIT   6

// Event flag bit positions
`define SSR_EVT_OPC_BIT   0
`define SSR_EVT_QYE_BIT   2
`define SSR_EVT_DDE_BIT   3
`define SSR_EVT_EXE_BIT   4
`define SSR_EVT_CME_BIT   5
`define SSR_EVT_PON_BIT   7

// Reset values
`define SSR_SRQ_MASK_RST  8'h00
`define SSR_EVT_MASK_RST  8'h00
`define SSR_EVT_FLAGS_RST 16'h0080

// Bits that can ever be set
`define SSR_EVT_USED      16'h00bd
`define SSR_STB_USED      8'h70

// Response queue depth
`define SSR_QUEUE_DEPTH   16

`endif

// [pkg/ssr_pkg.sv]
// Types for the status and service-request block
package ssr_pkg;

  typedef enum logic [1:0] {
    SSR_OPC_IDLE,
    SSR_OPC_ARMED
  } ssr_opc_state_t;

  typedef logic [7:0] ssr_byte_t;

endpackage : ssr_pkg

// [pkg/ssr_queue_if.sv]
// Carrier between the block top and its response queue
`timescale 1ns/1ps
interface ssr_queue_if;
  logic       push;
  logic [8:0] push_data;
  logic       pop;
  logic [8:0] pop_data;
  logic       nonempty;
  logic       full;
  logic       overflow;
  logic       underflow;

  modport owner (
    output push, push_data, pop,
    input  pop_data, nonempty, full, overflow, underflow
  );
  modport queue (
    input  push, push_data, pop,
    output pop_data, nonempty, full, overflow, underflow
  );
endinterface : ssr_queue_if

// [hw/ssr_resp_queue.sv]
// Response queue holding data bytes and end-of-message markers
`timescale 1ns/1ps
`include "ssr_map.svh"
module ssr_resp_queue #(
  parameter int DEPTH = `SSR_QUEUE_DEPTH
) (
  // Clock and reset
  input  wire logic ref_clk_i,
  input  wire logic resetn_i,
  // Queue port
  ssr_queue_if.queue q
);
  localparam int AW = $clog2(DEPTH);

  logic [8:0]  mem [DEPTH];
  logic [AW:0] cnt_reg;
  logic [AW-1:0] wr_reg;
  logic [AW-1:0] rd_reg;
  logic        ovf_reg;
  logic        unf_reg;
  logic [8:0]  out_reg;

  wire full_w  = (cnt_reg == (AW+1)'(DEPTH));
  wire empty_w = (cnt_reg == '0);
  wire do_push = q.push && !full_w;
  wire do_pop  = q.pop && !empty_w;

  assign q.nonempty  = !empty_w;
  assign q.full      = full_w;
  assign q.pop_data  = out_reg;
  assign q.overflow  = ovf_reg;
  assign q.underflow = unf_reg;

  always_ff @(posedge ref_clk_i) begin
    if (do_push) begin
      mem[wr_reg] <= q.push_data;
    end
  end

  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      cnt_reg <= '0;
      wr_reg  <= '0;
      rd_reg  <= '0;
      ovf_reg <= 1'b0;
      unf_reg <= 1'b0;
      out_reg <= 9'h000;
    end else begin
      wr_reg  <= do_push ? wr_reg + 1'b1 : wr_reg;
      rd_reg  <= do_pop ? rd_reg + 1'b1 : rd_reg;
      cnt_reg <= cnt_reg + (AW+1)'(do_push) - (AW+1)'(do_pop);
      // Pushing into a full queue loses the byte
      ovf_reg <= q.push && full_w;
      unf_reg <= q.pop && empty_w;
      // Read data holds until the next accepted read
      out_reg <= do_pop ? mem[rd_reg] : out_reg;
    end
  end
endmodule : ssr_resp_queue

// [verification/ssr_status_asserts.sv]
// Port-level assertions for the status and service-request block
`timescale 1ns/1ps
`include "ssr_map.svh"
module ssr_status_asserts (
  // Clock and reset
  input wire logic        ref_clk_i,
  input wire logic        resetn_i,
  // Requests
  input wire logic        command_error_i,
  input wire logic        execution_error_i,
  input wire logic        device_error_i,
  input wire logic        serial_poll_i,
  input wire logic        stb_query_i,
  input wire logic        srq_mask_wr_i,
  input wire logic        evt_mask_wr_i,
  input wire logic [7:0]  mask_wdata_i,
  input wire logic        evt_read_i,
  // Answers
  input wire logic [7:0]  stb_data_o,
  input wire logic        stb_valid_o,
  input wire logic [7:0]  srq_mask_o,
  input wire logic [7:0]  evt_mask_o,
  input wire logic [15:0] evt_data_o,
  input wire logic        srq_o
);
  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!resetn_i);

  sequence cme_then_read;
    command_error_i ##1 evt_read_i;
  endsequence
  // Two reads with no error event in between leave no error flag (bits 5 to 3) to report
  sequence quiet_reads;
    (evt_read_i &&
     !(command_error_i || execution_error_i || device_error_i))[*2];
  endsequence

  stb_unused_a: assert property (
    stb_valid_o |-> (stb_data_o & 8'h8f) == 8'h00)
    else $error("unused status bit set");
  evt_unused_a: assert property (
    (evt_data_o & ~`SSR_EVT_USED) == 16'h0000)
    else $error("unused event bit set");
  stb_answer_a: assert property (
    (serial_poll_i || stb_query_i) |=> stb_valid_o)
    else $error("status access not answered");
  rqs_summary_a: assert property (
    stb_valid_o |->
      stb_data_o[6] == |(stb_data_o[5:4] & srq_mask_o[5:4]))
    else $error("request bit differs from masked summary");
  srq_mask_a: assert property (
    srq_mask_wr_i |=> srq_mask_o == $past(mask_wdata_i))
    else $error("request mask not written");
  evt_mask_a: assert property (
    evt_mask_wr_i |=> evt_mask_o == $past(mask_wdata_i))
    else $error("event mask not written");
  cmd_error_a: assert property (
    cme_then_read |=> evt_data_o[5])
    else $error("command error not latched");
  clear_read_a: assert property (
    quiet_reads |=> evt_data_o[5:3] == 3'b000)
    else $error("event flags not cleared by read");
  srq_masked_a: assert property (
    ($past(srq_mask_o) == 8'h00 && srq_mask_o == 8'h00) |-> !srq_o)
    else $error("request line high with mask clear");
endmodule : ssr_status_asserts

bind ssr_status ssr_status_asserts u_chk (
  .ref_clk_i, .resetn_i, .command_error_i, .execution_error_i,
  .device_error_i, .serial_poll_i, .stb_query_i, .srq_mask_wr_i,
  .evt_mask_wr_i, .mask_wdata_i, .evt_read_i, .stb_data_o,
  .stb_valid_o, .srq_mask_o, .evt_mask_o, .evt_data_o, .srq_o
);

// [verification/ssr_ctrl_model.sv]
// Bus controller model that serial-polls on a service request
`timescale 1ns/1ps
module ssr_ctrl_model (
  // Clock and handler delay
  input wire logic       ref_clk_i,
  input wire logic [3:0] delay_i,
  // Status side of the block
  input wire logic       srq_o,
  input wire logic       stb_valid_o,
  input wire logic [7:0] stb_data_o,
  // Poll request and what it returned
  output logic           serial_poll_o,
  output logic [7:0]     polled_o,
  output int             polls_o
);
  // ****************************************
  // Request handler
  // ****************************************
  // serial poll inside handler
  initial begin
    serial_poll_o = 1'b0;
    polled_o = 8'h00;
    polls_o = 0;
    forever begin
      @(posedge srq_o);
      repeat (delay_i) @(negedge ref_clk_i);
      @(negedge ref_clk_i) serial_poll_o = 1'b1;
      @(negedge ref_clk_i) serial_poll_o = 1'b0;
      polled_o = stb_valid_o ? stb_data_o : 8'hff;
      polls_o++;
    end
  end
endmodule : ssr_ctrl_model

// [verification/ssr_status_test.sv]
// Self-checking bench for the status and service-request block
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin tests_run++; if ((got) !== (ex)) begin \
  n_fail++; $display("ERROR %s exp %h got %h", nm, ex, got); end end
module ssr_status_test;
  import ssr_pkg::*;
  logic ref_clk_i, resetn_i, power_good_i, opc_monitor_i, ops_pending_i;
  logic resp_push_i, resp_end_i, resp_read_i, serial_poll_i, stb_query_i;
  logic srq_mask_wr_i, evt_mask_wr_i, evt_read_i, resp_ready_o, srq_o;
  logic resp_end_o, resp_valid_o, stb_valid_o, evt_valid_o;
  logic [2:0] err;
  logic [3:0] dly;
  ssr_byte_t resp_data_i, mask_wdata_i, resp_data_o, stb_data_o;
  ssr_byte_t srq_mask_o, evt_mask_o, polled;
  logic [15:0] evt_data_o;
  int n_fail, tests_run, polls, i;

  ssr_status uut (.ref_clk_i, .resetn_i, .power_good_i,
    .command_error_i(err[2]), .execution_error_i(err[1]),
    .device_error_i(err[0]), .opc_monitor_i, .ops_pending_i,
    .resp_push_i, .resp_data_i, .resp_end_i, .resp_ready_o,
    .resp_read_i, .resp_data_o, .resp_end_o, .resp_valid_o,
    .serial_poll_i, .stb_query_i, .stb_data_o, .stb_valid_o,
    .srq_mask_wr_i, .evt_mask_wr_i, .mask_wdata_i, .srq_mask_o,
    .evt_mask_o, .evt_read_i, .evt_data_o, .evt_valid_o, .srq_o);
  ssr_ctrl_model ctrl (.ref_clk_i, .delay_i(dly), .srq_o, .stb_valid_o,
    .stb_data_o, .serial_poll_o(serial_poll_i), .polled_o(polled),
    .polls_o(polls));

  initial begin
    ref_clk_i = 1'b0;
    forever #20 ref_clk_i = ~ref_clk_i;
  end

  // ****************************************
  // Access tasks, entered and left at a falling edge
  // ****************************************
  task automatic conclude;
    $display("checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : conclude
  task automatic stb_q(input ssr_byte_t ex);
    stb_query_i = 1'b1;
    @(negedge ref_clk_i) stb_query_i = 1'b0;
    `CHK("stb_valid", 1'b1, stb_valid_o)
    `CHK("stb_data", ex, stb_data_o)
    @(negedge ref_clk_i);
  endtask : stb_q
  task automatic rd_evt(input logic [15:0] ex);
    evt_read_i = 1'b1;
    @(negedge ref_clk_i) evt_read_i = 1'b0;
    `CHK("evt_valid", 1'b1, evt_valid_o)
    `CHK("evt_data", ex, evt_data_o)
    @(negedge ref_clk_i);
  endtask : rd_evt
  // Back-to-back reads: the second sees the flags left after the first cleared them
  task automatic rd_evt2(input logic [15:0] ex1, input logic [15:0] ex2);
    evt_read_i = 1'b1;
    @(negedge ref_clk_i) `CHK("evt_valid", 1'b1, evt_valid_o)
    `CHK("evt_data", ex1, evt_data_o)
    @(negedge ref_clk_i) evt_read_i = 1'b0;
    `CHK("evt_valid", 1'b1, evt_valid_o)
    `CHK("evt_data", ex2, evt_data_o)
    @(negedge ref_clk_i);
  endtask : rd_evt2
  task automatic wr_mask(input logic srq, input ssr_byte_t d);
    srq_mask_wr_i = srq;
    evt_mask_wr_i = !srq;
    mask_wdata_i = d;
    @(negedge ref_clk_i) {srq_mask_wr_i, evt_mask_wr_i} = 2'b00;
    @(negedge ref_clk_i) `CHK("mask", d, srq ? srq_mask_o : evt_mask_o)
  endtask : wr_mask
  task automatic pulse_err(input logic [2:0] e);
    err = e;
    @(negedge ref_clk_i) err = 3'b000;
  endtask : pulse_err
  task automatic push(input ssr_byte_t d, input logic e);
    {resp_push_i, resp_data_i, resp_end_i} = {1'b1, d, e};
    @(negedge ref_clk_i) resp_push_i = 1'b0;
    @(negedge ref_clk_i);
  endtask : push
  task automatic rd_resp(input logic v, input ssr_byte_t d, input logic e);
    resp_read_i = 1'b1;
    @(negedge ref_clk_i) resp_read_i = 1'b0;
    `CHK("resp_valid", v, resp_valid_o)
    if (v) `CHK("resp", {d, e}, {resp_data_o, resp_end_o})
    @(negedge ref_clk_i);
  endtask : rd_resp
  // Bounded waits; running out counts a mismatch and ends the run
  task automatic wait_srq(input logic lvl);
    for (int k = 0; k < 30 && srq_o !== lvl; k++) @(negedge ref_clk_i);
    `CHK("srq", lvl, srq_o)
    if (srq_o !== lvl) conclude();
  endtask : wait_srq
  task automatic wait_poll(input int n, input ssr_byte_t ex);
    for (int k = 0; k < 40 && polls < n; k++) @(negedge ref_clk_i);
    `CHK("polls", n, polls)
    `CHK("polled", ex, polled)
    if (polls < n) conclude();
  endtask : wait_poll

  // ****************************************
  // Test sequence
  // ****************************************
  initial begin
    {resetn_i, power_good_i, opc_monitor_i, ops_pending_i} = 4'h0;
    {resp_push_i, resp_end_i, resp_read_i, stb_query_i} = 4'h0;
    {srq_mask_wr_i, evt_mask_wr_i, evt_read_i, err, dly} = 10'h000;
    {resp_data_i, mask_wdata_i, n_fail, tests_run} = '0;
    repeat (6) @(posedge ref_clk_i);
    @(negedge ref_clk_i) {resetn_i, power_good_i} = 2'b11;
    repeat (5) @(negedge ref_clk_i);
    rd_evt2(16'h0080, 16'h0000);
    for (i = 0; i < 3; i++) begin
      pulse_err(3'b100 >> i);
      rd_evt(16'h0020 >> i);
    end
    $display("test events done");
    {ops_pending_i, opc_monitor_i} = 2'b11;
    @(negedge ref_clk_i) opc_monitor_i = 1'b0;
    repeat (3) @(negedge ref_clk_i);
    rd_evt(16'h0000);
    ops_pending_i = 1'b0;
    repeat (2) @(negedge ref_clk_i);
    rd_evt(16'h0001);
    $display("test op_complete done");
    rd_resp(1'b0, 8'h00, 1'b0);
    rd_evt(16'h0004);
    for (i = 0; i < 16; i++) push(i[7:0], i == 15);
    `CHK("ready", 1'b0, resp_ready_o)
    stb_q(8'h10);
    push(8'haa, 1'b1);
    rd_evt(16'h0004);
    for (i = 0; i < 16; i++) rd_resp(1'b1, i[7:0], i == 15);
    stb_q(8'h00);
    $display("test queue done");
    wr_mask(1'b0, 8'h20);
    wr_mask(1'b1, 8'h20);
    pulse_err(3'b100);
    wait_srq(1'b1);
    wait_poll(1, 8'h60);
    stb_q(8'h60);
    wr_mask(1'b1, 8'h00);
    stb_q(8'h20);
    rd_evt(16'h0020);
    stb_q(8'h00);
    dly = 4'h6;
    wr_mask(1'b1, 8'h10);
    push(8'h5a, 1'b1);
    wait_srq(1'b1);
    wait_poll(2, 8'h50);
    rd_resp(1'b1, 8'h5a, 1'b1);
    wait_srq(1'b0);
    stb_q(8'h00);
    $display("test service_request done");
    conclude();
  end
endmodule : ssr_status_test
